// *** bcaiu_locid.sv ***
// Purpose: Turns an operand location into an area code and word address.
// Assumes: Purely combinational; fed from logic on the same clock.
// Notes:   Areas without a code, bad banks and out-of-range words fault.
`include "bcaiu_regs.svh"
`default_nettype none

module bcaiu_locid
(
   input  wire bcaiu_pkg::bcaiu_addr_type      loc,
   output logic [`BCAIU_WORD_W-1:0]            area_code,
   output logic [`BCAIU_WORD_W-1:0]            word_addr,
   output logic                                fault
);

   logic [`BCAIU_WORD_W-1:0] limit;

   // ---------------------------------------------------------------
   // Area decode
   // ---------------------------------------------------------------
   always_comb
   begin
      area_code = '0;
      limit     = '0;
      fault     = 1'b0;
      case (loc.area)
         bcaiu_pkg::AREA_CORE_IO :
         begin
            area_code = `BCAIU_CODE_CIO;
            limit     = `BCAIU_LIM_CIO;
         end
         bcaiu_pkg::AREA_WORK :
         begin
            area_code = `BCAIU_CODE_WORK;
            limit     = `BCAIU_LIM_WH;
         end
         bcaiu_pkg::AREA_HOLD :
         begin
            area_code = `BCAIU_CODE_HOLD;
            limit     = `BCAIU_LIM_WH;
         end
         bcaiu_pkg::AREA_DATA_MEM :
         begin
            area_code = `BCAIU_CODE_DM;
            limit     = `BCAIU_LIM_MEM;
         end
         bcaiu_pkg::AREA_EXT_MEM :
         begin
            area_code = `BCAIU_CODE_EM_BASE | {12'h000, loc.bank};
            limit     = `BCAIU_LIM_MEM;
            fault     = (loc.bank > `BCAIU_BANK_MAX);
         end
         default :
         begin
            fault = 1'b1;
         end
      endcase
      if (loc.word > limit)
      begin
         fault = 1'b1;
      end
   end

   assign word_addr = loc.word;

endmodule // bcaiu_locid

`default_nettype wire

// *** bcaiu_mem_model.sv ***
// Purpose: Word memory that stands behind bcaiu_top.
// Assumes: One read outstanding; writes are taken every cycle and dropped.
// Notes:   A word reads back as its address inverted, two cycles late.
`default_nettype none
module bcaiu_mem_model
(
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      rd_req,
   input  wire bcaiu_pkg::bcaiu_addr_type rd_addr,
   output logic                           rd_valid,
   output logic [15:0]                    rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        p_q;
   logic [15:0] w_q;
   // Idle data toggles so a stale word is never mistaken for an answer.
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         {p_q, w_q, rd_valid, rd_data} <= '0;
      end
      else
      begin
         p_q      <= rd_req;
         w_q      <= ~rd_addr.word;
         rd_valid <= p_q;
         rd_data  <= p_q ? w_q : ~rd_data;
      end
endmodule // bcaiu_mem_model
`default_nettype wire

// *** bcaiu_pkg.sv ***
// Purpose: Types shared by the bit count and area identify unit.
// Assumes: bcaiu_regs.svh supplies the widths.
// Notes:   Nothing here is imported; users write bcaiu_pkg::name.
`include "bcaiu_regs.svh"
`default_nettype none

package bcaiu_pkg;

   // ---------------------------------------------------------------
   // Enumerations
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      AREA_CORE_IO,
      AREA_WORK,
      AREA_HOLD,
      AREA_AUX,
      AREA_TIMER,
      AREA_COUNTER,
      AREA_DATA_MEM,
      AREA_EXT_MEM
   } bcaiu_area_type;

   typedef enum logic [1:0] {
      OP_BIT_COUNT,
      OP_LOCATION_ID,
      OP_BIT_MOVE
   } bcaiu_op_type;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      bcaiu_area_type              area;
      logic [3:0]                  bank;
      logic [`BCAIU_WORD_W-1:0]    word;
   } bcaiu_addr_type;

   typedef struct packed {
      bcaiu_op_type op;
      logic         cond;
      logic         upward;
   } bcaiu_cmd_type;

   typedef struct packed {
      logic [`BCAIU_WORD_W-1:0] num;
      logic [`BCAIU_WORD_W-1:0] move_src;
      bcaiu_addr_type           src;
      bcaiu_addr_type           dest1;
      bcaiu_addr_type           dest2;
   } bcaiu_opnd_type;

endpackage

`default_nettype wire

// *** bcaiu_popcnt.sv ***
// Purpose: Counts the one bits of a word.
// Assumes: Purely combinational.
// Notes:   Chain of partial sums built by a generate loop.
`default_nettype none

module bcaiu_popcnt
#(
   parameter int W = 16
)
(
   input  wire logic [W-1:0]           word,
   output logic      [$clog2(W+1)-1:0] ones
);

   localparam int CW = $clog2(W+1);

   logic [CW-1:0] part [0:W];

   assign part[0] = '0;

   // ---------------------------------------------------------------
   // Partial sums
   // ---------------------------------------------------------------
   for (genvar i = 0; i < W; i++)
   begin : g_sum
      assign part[i+1] = part[i] + CW'(word[i]);
   end

   assign ones = part[W];

endmodule // bcaiu_popcnt

`default_nettype wire

// *** bcaiu_properties.sv ***
// Purpose: Port assertions for bcaiu_top.
// Assumes: One clock, NRST asynchronous and active low.
// Notes:   Bound to every bcaiu_top instance.
`default_nettype none
module bcaiu_properties
(
   input wire logic CLOCK, NRST, CMD_VALID, MEM_RD_VALID, BUSY, DONE,
   input wire logic FAULT_FLAG, EQUALS_FLAG, MEM_RD_REQ, MEM_WR_REQ,
   input wire bcaiu_pkg::bcaiu_cmd_type CMD,
   input wire bcaiu_pkg::bcaiu_opnd_type OPND,
   input wire bcaiu_pkg::bcaiu_addr_type MEM_RD_ADDR, MEM_WR_ADDR,
   input wire logic [15:0] MEM_RD_DATA, MEM_WR_DATA
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   bcaiu_pkg::bcaiu_op_type   op_q;
   bcaiu_pkg::bcaiu_addr_type ra_q;
   logic                      wr_q, rd_q, wz_q;
   logic [15:0]               rv_q;
   always_ff @(posedge CLOCK or negedge NRST)
      if (!NRST)
      begin
         op_q <= bcaiu_pkg::OP_BIT_COUNT;
         {ra_q, wr_q, rd_q, wz_q, rv_q} <= '0;
      end
      else
      begin
         if (CMD_VALID && !BUSY) op_q <= CMD.op;
         if (CMD_VALID && !BUSY) {wr_q, rd_q} <= 2'b00;
         if (MEM_WR_REQ) {wr_q, wz_q} <= {1'b1, MEM_WR_DATA == 16'h0000};
         if (MEM_RD_REQ) {rd_q, ra_q} <= {1'b1, MEM_RD_ADDR};
         if (MEM_RD_VALID) rv_q <= MEM_RD_DATA;
      end
   sequence s_bad_n;
      CMD_VALID && !BUSY && CMD.op == bcaiu_pkg::OP_BIT_COUNT && CMD.cond && !CMD.upward && OPND.num == 16'h0000;
   endsequence
   sequence s_cnt_wr;
      MEM_WR_REQ && op_q == bcaiu_pkg::OP_BIT_COUNT;
   endsequence
   property p_bad_n; s_bad_n |-> ##1 DONE ##1 FAULT_FLAG; endproperty
   property p_bcd; s_cnt_wr |-> MEM_WR_DATA[15:12] <= 4'h9 && MEM_WR_DATA[11:8] <= 4'h9
      && MEM_WR_DATA[7:4] <= 4'h9 && MEM_WR_DATA[3:0] <= 4'h9; endproperty
   property p_eq; s_cnt_wr |-> ##1 DONE ##1 (EQUALS_FLAG == wz_q && !FAULT_FLAG); endproperty
   property p_code; MEM_WR_REQ && op_q == bcaiu_pkg::OP_LOCATION_ID && !wr_q |-> MEM_WR_DATA inside
      {16'h00b0, 16'h00b1, 16'h00b2, 16'h0082, [16'h00a0:16'h00ac]}; endproperty
   property p_addr; MEM_WR_REQ && op_q == bcaiu_pkg::OP_LOCATION_ID && wr_q |-> MEM_WR_DATA <= 16'h7fff ##1 DONE;
   endproperty
   property p_nowr; DONE ##1 FAULT_FLAG |-> !wr_q; endproperty
   property p_rdseq; MEM_RD_REQ && op_q == bcaiu_pkg::OP_BIT_COUNT && rd_q |->
      MEM_RD_ADDR.word == ra_q.word + 16'h0001 && MEM_RD_ADDR.area == ra_q.area; endproperty
   property p_move; MEM_WR_REQ && op_q == bcaiu_pkg::OP_BIT_MOVE |-> $onehot0(MEM_WR_DATA ^ rv_q); endproperty
   a_bad_n: assert property (p_bad_n) else $error("zero count not faulted");
   a_bcd: assert property (p_bcd) else $error("count result not decimal");
   a_eq: assert property (p_eq) else $error("equals flag wrong");
   a_code: assert property (p_code) else $error("bad area code");
   a_addr: assert property (p_addr) else $error("bad word address");
   a_nowr: assert property (p_nowr) else $error("write on fault");
   a_rdseq: assert property (p_rdseq) else $error("source words not consecutive");
   a_move: assert property (p_move) else $error("bit move changed other bits");
endmodule // bcaiu_properties
bind bcaiu_top bcaiu_properties chk_u (.*);
`default_nettype wire

// *** bcaiu_regs.svh ***
// Purpose: Constants for the bit count and area identify unit.
// Assumes: Included by its bare name; definitions only.
// Notes:   Widths, area codes, address limits and count limits.
`ifndef BCAIU_REGS_SVH
`define BCAIU_REGS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define BCAIU_WORD_W       16
`define BCAIU_ACC_W        18
`define BCAIU_BIN_W        14
`define BCAIU_POS_W        7

// ---------------------------------------------------------------
// Limits and counts
// ---------------------------------------------------------------
`define BCAIU_COUNT_MAX    18'h0270f
`define BCAIU_BCD_DIGIT_MAX 4'h9
`define BCAIU_BITPOS_MAX   7'h0f
`define BCAIU_DABBLE_LAST  4'hd
`define BCAIU_BANK_MAX     4'hc

// ---------------------------------------------------------------
// Area codes and word address limits
// ---------------------------------------------------------------
`define BCAIU_CODE_CIO     16'h00b0
`define BCAIU_CODE_WORK    16'h00b1
`define BCAIU_CODE_HOLD    16'h00b2
`define BCAIU_CODE_DM      16'h0082
`define BCAIU_CODE_EM_BASE 16'h00a0
`define BCAIU_LIM_CIO      16'h17ff
`define BCAIU_LIM_WH       16'h01ff
`define BCAIU_LIM_MEM      16'h7fff

`endif

// *** bcaiu_top.sv ***
// Purpose: Datapath for the bit count, location identify and bit move ops.
// Assumes: Sequencer and data memory share CLOCK; memory takes a write
//          every cycle and answers each read with MEM_RD_VALID later.
// Notes:   One command at a time; CMD_VALID is ignored while BUSY is high.
`include "bcaiu_regs.svh"
`default_nettype none

module bcaiu_top
(
   input  wire logic                       CLOCK,
   input  wire logic                       NRST,
   input  wire logic                       CMD_VALID,
   input  wire bcaiu_pkg::bcaiu_cmd_type   CMD,
   input  wire bcaiu_pkg::bcaiu_opnd_type  OPND,
   input  wire logic                       MEM_RD_VALID,
   input  wire logic [`BCAIU_WORD_W-1:0]   MEM_RD_DATA,
   output logic                            BUSY,
   output logic                            DONE,
   output logic                            FAULT_FLAG,
   output logic                            EQUALS_FLAG,
   output logic                            MEM_RD_REQ,
   output bcaiu_pkg::bcaiu_addr_type       MEM_RD_ADDR,
   output logic                            MEM_WR_REQ,
   output bcaiu_pkg::bcaiu_addr_type       MEM_WR_ADDR,
   output logic [`BCAIU_WORD_W-1:0]        MEM_WR_DATA
);

   localparam int W = `BCAIU_WORD_W;
   localparam int CW = $clog2(W+1);

   typedef enum {
      ST_IDLE,
      ST_RD_REQ,
      ST_RD_WAIT,
      ST_CONV,
      ST_WR1,
      ST_WR2,
      ST_DONE
   } bcaiu_state_type;

   // ---------------------------------------------------------------
   // Decode functions
   // ---------------------------------------------------------------
   function automatic logic digit_ok(input logic [3:0] d);
      digit_ok = (d <= `BCAIU_BCD_DIGIT_MAX);
   endfunction

   function automatic logic [`BCAIU_POS_W-1:0] bcd2_bin(input logic [7:0] b);
      bcd2_bin = `BCAIU_POS_W'(b[7:4]) * `BCAIU_POS_W'(10) + `BCAIU_POS_W'(b[3:0]);
   endfunction

   function automatic logic half_ok(input logic [7:0] b);
      half_ok = digit_ok(b[7:4]) && digit_ok(b[3:0]) && (bcd2_bin(b) <= `BCAIU_BITPOS_MAX);
   endfunction

   function automatic logic [3:0] add3(input logic [3:0] d);
      add3 = (d > 4'h4) ? d + 4'h3 : d;
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   bcaiu_state_type            state_q;
   bcaiu_state_type            state_d;
   bcaiu_pkg::bcaiu_op_type    op_q;
   bcaiu_pkg::bcaiu_addr_type  rd_addr_q;
   bcaiu_pkg::bcaiu_addr_type  dest1_q;
   bcaiu_pkg::bcaiu_addr_type  dest2_q;
   logic [2:0]                 cond_hist_q;
   logic [`BCAIU_BIN_W-1:0]    remain_q;
   logic [`BCAIU_ACC_W-1:0]    acc_q;
   logic [`BCAIU_ACC_W-1:0]    acc_next;
   logic [`BCAIU_BIN_W-1:0]    shift_q;
   logic [W-1:0]               bcd_q;
   logic [3:0]                 iter_q;
   logic [W-1:0]               code_q;
   logic [W-1:0]               waddr_q;
   logic [W-1:0]               moved_q;
   logic [W-1:0]               move_src_q;
   logic [3:0]                 src_pos_q;
   logic [3:0]                 dst_pos_q;
   logic                       fault_q;
   logic                       fault_d;
   logic [CW-1:0]              ones;
   logic [W-1:0]               loc_code;
   logic [W-1:0]               loc_word;
   logic                       loc_fault;
   logic                       accept;
   logic                       exec;
   logic                       n_ok;
   logic                       ctl_ok;
   logic                       last_word;
   logic                       overflow;
   logic [`BCAIU_BIN_W-1:0]    n_bin;
   logic [W+`BCAIU_BIN_W-1:0]  conv_next;

   // ---------------------------------------------------------------
   // Operand checks
   // ---------------------------------------------------------------
   assign n_bin = `BCAIU_BIN_W'(OPND.num[15:12]) * `BCAIU_BIN_W'(1000)
                + `BCAIU_BIN_W'(OPND.num[11:8])  * `BCAIU_BIN_W'(100)
                + `BCAIU_BIN_W'(OPND.num[7:4])   * `BCAIU_BIN_W'(10)
                + `BCAIU_BIN_W'(OPND.num[3:0]);
   assign n_ok   = digit_ok(OPND.num[15:12]) && digit_ok(OPND.num[11:8]) &&
                   digit_ok(OPND.num[7:4]) && digit_ok(OPND.num[3:0]) &&
                   (n_bin != '0);
   assign ctl_ok = half_ok(OPND.num[15:8]) && half_ok(OPND.num[7:0]);

   // Prefixed form fires only when the condition was low on the last scan.
   assign accept = CMD_VALID && !BUSY;
   assign exec   = accept && CMD.cond && (!CMD.upward || !cond_hist_q[CMD.op]);

   // Read data is counted as raw bits; its decimal validity is never checked.
   assign acc_next  = acc_q + `BCAIU_ACC_W'(ones);
   assign last_word = (remain_q == `BCAIU_BIN_W'(1));
   assign overflow  = (acc_next > `BCAIU_COUNT_MAX);

   // One shift-and-add-three step over the BCD digits and the remaining binary bits.
   assign conv_next = {add3(bcd_q[15:12]), add3(bcd_q[11:8]), add3(bcd_q[7:4]), add3(bcd_q[3:0]),
                       shift_q} << 1;

   bcaiu_popcnt #(
      .W    (W)
   ) u_popcnt (
      .word (MEM_RD_DATA),
      .ones (ones)
   );

   bcaiu_locid u_locid (
      .loc       (OPND.src),
      .area_code (loc_code),
      .word_addr (loc_word),
      .fault     (loc_fault)
   );

   // ---------------------------------------------------------------
   // Sequencing
   // ---------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      fault_d = fault_q;
      case (state_q)
         ST_IDLE :
         begin
            if (exec)
            begin
               case (CMD.op)
                  bcaiu_pkg::OP_BIT_COUNT :
                  begin
                     fault_d = !n_ok;
                     state_d = n_ok ? ST_RD_REQ : ST_DONE;
                  end
                  bcaiu_pkg::OP_LOCATION_ID :
                  begin
                     fault_d = loc_fault;
                     state_d = loc_fault ? ST_DONE : ST_WR1;
                  end
                  default :
                  begin
                     fault_d = !ctl_ok;
                     state_d = ctl_ok ? ST_RD_REQ : ST_DONE;
                  end
               endcase
            end
         end
         ST_RD_REQ :
         begin
            state_d = ST_RD_WAIT;
         end
         ST_RD_WAIT :
         begin
            if (MEM_RD_VALID)
            begin
               if (op_q == bcaiu_pkg::OP_BIT_MOVE)
               begin
                  state_d = ST_WR1;
               end
               else if (last_word)
               begin
                  fault_d = overflow;
                  state_d = overflow ? ST_DONE : ST_CONV;
               end
               else
               begin
                  state_d = ST_RD_REQ;
               end
            end
         end
         ST_CONV :
         begin
            if (iter_q == `BCAIU_DABBLE_LAST)
            begin
               state_d = ST_WR1;
            end
         end
         ST_WR1 :
         begin
            state_d = (op_q == bcaiu_pkg::OP_LOCATION_ID) ? ST_WR2 : ST_DONE;
         end
         ST_WR2 :
         begin
            state_d = ST_DONE;
         end
         ST_DONE :
         begin
            state_d = ST_IDLE;
         end
         default :
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_q <= ST_IDLE;
         fault_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         fault_q <= fault_d;
      end
   end

   // ---------------------------------------------------------------
   // Condition history, one entry per operation
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         cond_hist_q <= 3'h0;
      end
      else if (accept)
      begin
         cond_hist_q[CMD.op] <= CMD.cond;
      end
   end

   // ---------------------------------------------------------------
   // Operand capture and source walk
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         op_q       <= bcaiu_pkg::OP_BIT_COUNT;
         rd_addr_q  <= '0;
         dest1_q    <= '0;
         dest2_q    <= '0;
         remain_q   <= '0;
         code_q     <= '0;
         waddr_q    <= '0;
         move_src_q <= '0;
         src_pos_q  <= 4'h0;
         dst_pos_q  <= 4'h0;
      end
      else if (state_q == ST_IDLE && exec)
      begin
         op_q       <= CMD.op;
         dest1_q    <= OPND.dest1;
         dest2_q    <= OPND.dest2;
         remain_q   <= n_bin;
         code_q     <= loc_code;
         waddr_q    <= loc_word;
         move_src_q <= OPND.move_src;
         src_pos_q  <= 4'(bcd2_bin(OPND.num[7:0]));
         dst_pos_q  <= 4'(bcd2_bin(OPND.num[15:8]));
         rd_addr_q  <= (CMD.op == bcaiu_pkg::OP_BIT_MOVE) ? OPND.dest1 : OPND.src;
      end
      else if (state_q == ST_RD_WAIT && MEM_RD_VALID)
      begin
         // The walk stays in one area; the program keeps the run inside it.
         rd_addr_q.word <= rd_addr_q.word + 16'h0001;
         remain_q       <= remain_q - `BCAIU_BIN_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // Accumulation, BCD conversion and bit merge
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         acc_q   <= '0;
         shift_q <= '0;
         bcd_q   <= '0;
         iter_q  <= 4'h0;
         moved_q <= '0;
      end
      else if (state_q == ST_IDLE)
      begin
         acc_q <= '0;
      end
      else if (state_q == ST_RD_WAIT && MEM_RD_VALID)
      begin
         acc_q   <= acc_next;
         shift_q <= acc_next[`BCAIU_BIN_W-1:0];
         bcd_q   <= '0;
         iter_q  <= 4'h0;
         moved_q <= MEM_RD_DATA;
         moved_q[dst_pos_q] <= move_src_q[src_pos_q];
      end
      else if (state_q == ST_CONV)
      begin
         // Shift-and-add-three: one binary bit enters per cycle.
         {bcd_q, shift_q} <= conv_next;
         iter_q <= iter_q + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Memory ports
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         MEM_RD_REQ  <= 1'b0;
         MEM_RD_ADDR <= '0;
         MEM_WR_REQ  <= 1'b0;
         MEM_WR_ADDR <= '0;
         MEM_WR_DATA <= '0;
      end
      else
      begin
         MEM_RD_REQ  <= (state_d == ST_RD_REQ);
         MEM_RD_ADDR <= (state_d == ST_RD_REQ) ?
                        ((state_q == ST_IDLE) ?
                         ((CMD.op == bcaiu_pkg::OP_BIT_MOVE) ? OPND.dest1 : OPND.src) :
                         bcaiu_pkg::bcaiu_addr_type'{area: rd_addr_q.area, bank: rd_addr_q.bank,
                                                     word: rd_addr_q.word + 16'h0001}) :
                        MEM_RD_ADDR;
         MEM_WR_REQ  <= (state_d == ST_WR1) || (state_d == ST_WR2);
         MEM_WR_ADDR <= (state_d == ST_WR2) ? dest2_q :
                        (state_q == ST_IDLE) ? OPND.dest1 : dest1_q;
         if (state_d == ST_WR2)
         begin
            MEM_WR_DATA <= waddr_q;
         end
         else if (state_q == ST_IDLE)
         begin
            MEM_WR_DATA <= loc_code;
         end
         else if (state_q == ST_RD_WAIT)
         begin
            MEM_WR_DATA <= MEM_RD_DATA ^
                           (W'(MEM_RD_DATA[dst_pos_q] ^ move_src_q[src_pos_q]) << dst_pos_q);
         end
         else if (state_q == ST_CONV)
         begin
            MEM_WR_DATA <= conv_next[W+`BCAIU_BIN_W-1:`BCAIU_BIN_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // Handshake and flags
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         BUSY        <= 1'b0;
         DONE        <= 1'b0;
         FAULT_FLAG  <= 1'b0;
         EQUALS_FLAG <= 1'b0;
      end
      else
      begin
         BUSY <= (state_d != ST_IDLE);
         DONE <= (state_d == ST_DONE);
         if (state_q == ST_DONE)
         begin
            FAULT_FLAG <= fault_q;
            if (op_q == bcaiu_pkg::OP_BIT_COUNT)
            begin
               EQUALS_FLAG <= !fault_q && (acc_q == '0);
            end
         end
      end
   end

endmodule // bcaiu_top

`default_nettype wire

// *** bit_count_and_area_id_unit_test.sv ***
// Purpose: Self-checking bench for bcaiu_top.
// Assumes: 50 MHz clock; reset low for ten cycles.
// Notes:   Each scenario task drives and judges its own results.
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: %h vs %h", $time, a, b); end end
module bit_count_and_area_id_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef bcaiu_pkg::bcaiu_addr_type bcaiu_adr_type;
   localparam bcaiu_pkg::bcaiu_area_type dm = bcaiu_pkg::AREA_DATA_MEM;
   localparam bcaiu_adr_type res_a = '{bcaiu_pkg::AREA_DATA_MEM, 4'h0, 16'h0100};
   logic CLOCK = 0, NRST = 0, CMD_VALID = 0, MEM_RD_VALID, BUSY, DONE, FAULT_FLAG, EQUALS_FLAG, MEM_RD_REQ, MEM_WR_REQ;
   bcaiu_pkg::bcaiu_cmd_type  CMD = '0;
   bcaiu_pkg::bcaiu_opnd_type OPND = '0;
   bcaiu_adr_type             MEM_RD_ADDR, MEM_WR_ADDR, wa[2];
   logic [15:0]               MEM_RD_DATA, MEM_WR_DATA, wv[2];
   int                        fail_count = 0, n_tests = 0, wr_n = 0, cyc = 0;
   logic                      dn;
   always #10 CLOCK = ~CLOCK;
   bcaiu_top dut_u (.*);
   bcaiu_mem_model mem_u (.clk(CLOCK), .nrst(NRST), .rd_req(MEM_RD_REQ), .rd_addr(MEM_RD_ADDR),
      .rd_valid(MEM_RD_VALID), .rd_data(MEM_RD_DATA));
   always @(posedge CLOCK)
   begin
      cyc <= cyc + 1;
      if (MEM_WR_REQ && wr_n < 2) wv[wr_n] <= MEM_WR_DATA;
      if (MEM_WR_REQ && wr_n < 2) wa[wr_n] <= MEM_WR_ADDR;
      if (MEM_WR_REQ) wr_n <= wr_n + 1;
      if (cyc == 90000)
      begin
         fail_count++;
         end_sim;
      end
   end
   function automatic bcaiu_adr_type ad(bcaiu_pkg::bcaiu_area_type a, logic [3:0] b, logic [15:0] w);
      return '{a, b, w};
   endfunction
   task end_sim;
      $display("Checks %0d, errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Issues one command and returns one cycle after DONE, when the flags have settled.
   task automatic op(logic [1:0] o, logic c, u, logic [15:0] n, m, bcaiu_adr_type s, d);
      wr_n = 0;
      dn = 0;
      @(posedge CLOCK);
      CMD_VALID <= 1;
      CMD <= '{bcaiu_pkg::bcaiu_op_type'(o), c, u};
      OPND <= '{n, m, s, d, ad(dm, 4'h0, 16'h0300)};
      @(posedge CLOCK);
      CMD_VALID <= 0;
      for (int k = 0; k < 8000 && dn !== 1'b1; k++)
      begin
         #1;
         dn = DONE;
         @(posedge CLOCK);
      end
      #1;
   endtask
   task t_count;
      op(0, 1, 0, 16'h0003, 0, ad(dm, 0, 16'hff00), res_a);
      `CHK({dn, wr_n == 1, FAULT_FLAG, EQUALS_FLAG, wv[0]}, {4'b1100, 16'h0022})
      `CHK({BUSY, wa[0]}, {1'b0, res_a})
      op(0, 1, 0, 16'h0001, 0, ad(dm, 0, 16'hffff), res_a);
      `CHK({wr_n == 1, FAULT_FLAG, EQUALS_FLAG, wv[0]}, {3'b101, 16'h0000})
   endtask
   task t_bad;
      logic [15:0] nv[3];
      nv = '{16'h0000, 16'h000a, 16'ha000};
      foreach (nv[i])
      begin
         op(0, 1, 0, nv[i], 0, ad(dm, 0, 16'h0000), res_a);
         `CHK({dn, wr_n == 0, FAULT_FLAG, EQUALS_FLAG}, 4'b1110)
      end
      op(0, 1, 0, 16'h1000, 0, ad(dm, 0, 16'h0000), res_a);
      `CHK({dn, wr_n == 0, FAULT_FLAG}, 3'b111)
   endtask
   task t_edge;
      logic [2:0] e;
      op(0, 0, 0, 16'h0001, 0, ad(dm, 0, 16'hff00), res_a);
      e[2] = dn;
      op(0, 1, 1, 16'h0001, 0, ad(dm, 0, 16'hff00), res_a);
      e[1] = dn;
      op(0, 1, 1, 16'h0001, 0, ad(dm, 0, 16'hff00), res_a);
      e[0] = dn;
      `CHK(e, 3'b010)
   endtask
   task t_locid;
      bcaiu_adr_type s[8];
      logic [15:0]   c[8];
      s = '{ad(bcaiu_pkg::AREA_CORE_IO, 0, 16'h17ff), ad(bcaiu_pkg::AREA_WORK, 0, 16'h01ff),
         ad(bcaiu_pkg::AREA_HOLD, 0, 16'h0000), ad(dm, 0, 16'h7fff), ad(bcaiu_pkg::AREA_EXT_MEM, 4'hc, 16'h1234),
         ad(bcaiu_pkg::AREA_CORE_IO, 0, 16'h1800), ad(bcaiu_pkg::AREA_EXT_MEM, 4'hd, 16'h0000),
         ad(bcaiu_pkg::AREA_AUX, 0, 16'h0000)};
      c = '{16'h00b0, 16'h00b1, 16'h00b2, 16'h0082, 16'h00ac, 16'h0000, 16'h0000, 16'h0000};
      foreach (s[i])
      begin
         op(1, 1, 0, 0, 0, s[i], res_a);
         `CHK({FAULT_FLAG, wr_n == (c[i] != 0 ? 2 : 0)}, {c[i] == 0, 1'b1})
         if (c[i] != 0) `CHK({wv[0], wv[1]}, {c[i], s[i].word})
         if (c[i] != 0) `CHK({wa[0], wa[1]}, {res_a, ad(dm, 0, 16'h0300)})
      end
   endtask
   task t_move;
      op(2, 1, 0, 16'h1205, 16'h0020, 0, ad(dm, 0, 16'hffff));
      `CHK({FAULT_FLAG, wr_n == 1, wv[0]}, {2'b01, 16'h1000})
      op(2, 1, 0, 16'h1205, 16'hffdf, 0, ad(dm, 0, 16'h0000));
      `CHK({FAULT_FLAG, wr_n == 1, wv[0]}, {2'b01, 16'hefff})
      op(2, 1, 0, 16'h0016, 16'hffff, 0, ad(dm, 0, 16'h0000));
      `CHK({dn, FAULT_FLAG, wr_n == 0}, 3'b111)
   endtask
   initial
   begin
      repeat (10) @(posedge CLOCK);
      NRST <= 1;
      t_bad;
      t_count;
      t_edge;
      t_locid;
      t_move;
      end_sim;
   end
endmodule // bit_count_and_area_id_unit_test
`default_nettype wire
